// ==== src/dfpm_ctrl.sv ====
// Fast page mode DRAM sequencer: page tracking, strobes, bursts, precharge
//
// Functional notes
// [RQ1] Latch row on page-opening transfer; compare later addresses for hit or miss.
// [RQ2] 512-byte pages: hit when address bits 31..9 equal the stored row.
// [RQ3] 1-kilobyte pages: hit when address bits 31..10 equal the stored row.
// [RQ4] 2-kilobyte pages: hit when address bits 31..11 equal the stored row.
// [RQ5] Row strobe stays low over page hits; hits drive column address and CAS.
// [RQ6] Close page on miss, other-bank transfer, lost mastership or pending refresh.
// [RQ7] After closing, block that bank until row precharge time has elapsed.
// [RQ8] Operand wider than port becomes a burst of two to sixteen segments.
// [RQ9] Start strobe once per transfer; acknowledge once per segment.
// [RQ10] Each secondary segment waits for programmed precharge.
// [RQ11] Fastest burst three clocks then two per segment; timing programmable.
// [RQ12] Opening write: start with row address, RAS, then column and data, CAS.
// [RQ13] Between segments only CAS negates; next column and data then CAS.
// [RQ14] Write data drivers release when the write or burst completes.
// [RQ15] Page-hit read waits for column precharge of that bank.
// [RQ16] Page-hit read fastest two clocks per segment.
// [RQ17] Page-hit write asserts CAS one cycle later than a read; data first.
// [RQ18] Page-hit write fastest three clocks, secondary writes two clocks.
// [RQ19] Page-hit read: start with column address, high write line, then CAS.
// [RQ20] Page-hit timing independent of how the page was opened.
// [RQ21] Acknowledge a cycle before completion; read data captured at its end.
// [RQ22] Page miss waits row precharge; fastest four clocks in total.
// [RQ23] Transfer to the other bank starts without precharge delay.
// [RQ24] Grant lost unlocked: bus driven held until transfer ends, then precharge.
// [RQ25] Per-bank row and column precharge counters stall new strobes.
// [RQ26] Column strobe lanes chosen from port width and address.
`timescale 1ns/10ps
module dfpm_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Core request
    input wire logic req_valid_i,
    input wire dfpm_pkg::dfpm_req_t req_i,
    output logic req_ready_o,
    output logic transfer_ack_o,
    output logic [dfpm_pkg::OPER_W-1:0] rdata_o,
    output logic rdata_valid_o,
    // Configuration
    input wire logic [dfpm_pkg::NUM_BANKS-1:0][1:0] bank_page_size_i,
    input wire logic [dfpm_pkg::NUM_BANKS-1:0][1:0] port_width_i,
    input wire dfpm_pkg::dfpm_timing_t dram_timing_reg_i,
    // System
    input wire logic refresh_pend_i,
    input wire logic bus_lock_i,
    input wire logic bus_grant_in_n_i,
    output logic bus_driven_n_o,
    // DRAM pins
    output dfpm_pkg::dfpm_pins_t pins_o,
    input wire logic [dfpm_pkg::DATA_W-1:0] dram_rdata_i
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] oper_log2(input logic [1:0] opw);
        logic [2:0] r;
        r = dfpm_pkg::LOG_4;
        unique case (opw)
            dfpm_pkg::OPW_LONG: r = dfpm_pkg::LOG_4;
            dfpm_pkg::OPW_BYTE: r = dfpm_pkg::LOG_1;
            dfpm_pkg::OPW_WORD: r = dfpm_pkg::LOG_2;
            dfpm_pkg::OPW_LINE: r = dfpm_pkg::LOG_16;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] port_log2(input logic [1:0] pw);
        logic [2:0] r;
        r = dfpm_pkg::LOG_4;
        unique case (pw)
            dfpm_pkg::PORT_32: r = dfpm_pkg::LOG_4;
            dfpm_pkg::PORT_8: r = dfpm_pkg::LOG_1;
            dfpm_pkg::PORT_16: r = dfpm_pkg::LOG_2;
            default: r = dfpm_pkg::LOG_4;
        endcase
        return r;
    endfunction

    // Stored row bits above the page size must match
    function automatic logic row_match(input logic [dfpm_pkg::ADDR_W-1:0] a,
                                       input logic [dfpm_pkg::ROW_W-1:0] row,
                                       input logic [1:0] ps);
        logic [dfpm_pkg::ROW_W-1:0] diff;
        diff = (a[dfpm_pkg::ADDR_W-1:dfpm_pkg::ROW_LSB] ^ row) >> ps; // [RQ2] [RQ3] [RQ4]
        return diff == '0;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dfpm_pkg::dfpm_state_t state_q, state_d;
    dfpm_pkg::dfpm_req_t req_q;
    logic [dfpm_pkg::SEG_W-1:0] seg_left_q;
    logic [dfpm_pkg::OPER_W-1:0] wsh_q;
    logic [dfpm_pkg::OPER_W-1:0] rsh_q;
    logic rdata_valid_q;
    logic [dfpm_pkg::NUM_BANKS-1:0] open_q;
    logic [dfpm_pkg::ROW_W-1:0] row_q [dfpm_pkg::NUM_BANKS];
    logic bus_driven_q;
    logic grant_meta_q, grant_s2_q, grant_s3_q, grant_q;

    // ------------------------------------------------------------
    // Bus grant synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            grant_meta_q <= 1'b1;
            grant_s2_q <= 1'b1;
            grant_s3_q <= 1'b1;
            grant_q <= 1'b0;
        end else begin
            grant_meta_q <= bus_grant_in_n_i;
            grant_s2_q <= grant_meta_q;
            grant_s3_q <= grant_s2_q;
            if (grant_s2_q == grant_s3_q) begin
                grant_q <= ~grant_s2_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic rb;
    logic tgt_open, other_open, hit, grant_ok, accept;
    logic [dfpm_pkg::NUM_BANKS-1:0] row_busy, col_busy, close_v, open_v, col_load;
    logic [2:0] req_olog, req_plog;
    logic [dfpm_pkg::SEG_W-1:0] req_nseg;
    logic [dfpm_pkg::SHIFT_W-1:0] req_wshift;

    assign rb = req_i.bank;
    assign tgt_open = open_q[rb];
    assign other_open = open_q[~rb];
    assign hit = tgt_open && row_match(req_i.addr, row_q[rb], bank_page_size_i[rb]); // [RQ1]
    assign grant_ok = grant_q || bus_lock_i;
    assign req_olog = oper_log2(req_i.opw);
    assign req_plog = port_log2(port_width_i[rb]);
    assign req_nseg = (req_olog > req_plog) ? (dfpm_pkg::ONE_SEG << (req_olog - req_plog))
                                            : dfpm_pkg::ONE_SEG; // [RQ8]
    assign req_wshift = dfpm_pkg::OPER_BITS - (dfpm_pkg::BYTE_BITS << req_olog);

    // Hits wait for column precharge, new pages for row precharge
    always_comb begin
        req_ready_o = 1'b0;
        if (state_q == dfpm_pkg::ST_IDLE && grant_ok && !refresh_pend_i && !row_busy[rb]) begin
            req_ready_o = !tgt_open || (hit && !col_busy[rb]); // [RQ7] [RQ15] [RQ22] [RQ25]
        end
    end
    assign accept = req_valid_i && req_ready_o;

    // Page closing and opening per bank
    always_comb begin
        close_v = '0;
        open_v = '0;
        if (state_q == dfpm_pkg::ST_IDLE) begin
            if (!grant_ok || refresh_pend_i) begin
                close_v = open_q; // [RQ6] [RQ24]
            end else if (req_valid_i && tgt_open && !hit) begin
                close_v[rb] = 1'b1; // [RQ6] [RQ22]
            end else if (accept && other_open) begin
                close_v[~rb] = 1'b1; // [RQ6] [RQ23]
            end
            if (accept && !hit) begin
                open_v[rb] = 1'b1;
            end
        end
    end

    always_comb begin
        col_load = '0;
        if (state_q == dfpm_pkg::ST_ACK) begin
            col_load[req_q.bank] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per-bank page and precharge tracking
    // ------------------------------------------------------------
    for (genvar b = 0; b < dfpm_pkg::NUM_BANKS; b++) begin : g_bank
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                open_q[b] <= 1'b0;
                row_q[b] <= '0;
            end else if (open_v[b]) begin
                open_q[b] <= 1'b1; // [RQ5]
                row_q[b] <= req_i.addr[dfpm_pkg::ADDR_W-1:dfpm_pkg::ROW_LSB]; // [RQ1]
            end else if (close_v[b]) begin
                open_q[b] <= 1'b0;
            end
        end

        dfpm_prech_cnt #(
            .CNT_W(dfpm_pkg::TIM_W)
        ) u_row_cnt (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .load_i(close_v[b]),
            .value_i(dram_timing_reg_i.row_prech),
            .busy_o(row_busy[b])
        ); // [RQ7] [RQ25]

        dfpm_prech_cnt #(
            .CNT_W(dfpm_pkg::TIM_W)
        ) u_col_cnt (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .load_i(col_load[b]),
            .value_i(dram_timing_reg_i.col_prech),
            .busy_o(col_busy[b])
        ); // [RQ10] [RQ25]
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            dfpm_pkg::ST_IDLE: begin
                if (accept) begin
                    if (!hit) begin
                        state_d = dfpm_pkg::ST_ROW; // [RQ12]
                    end else if (req_i.write) begin
                        state_d = dfpm_pkg::ST_HITW; // [RQ17] [RQ18]
                    end else begin
                        state_d = dfpm_pkg::ST_HITR; // [RQ16] [RQ19] [RQ20]
                    end
                end
            end
            dfpm_pkg::ST_ROW: state_d = dfpm_pkg::ST_COL;
            dfpm_pkg::ST_HITW: state_d = dfpm_pkg::ST_COL; // [RQ17]
            dfpm_pkg::ST_HITR: state_d = dfpm_pkg::ST_ACK;
            dfpm_pkg::ST_COL: begin
                if (!col_busy[req_q.bank]) begin
                    state_d = dfpm_pkg::ST_ACK; // [RQ10] [RQ11]
                end
            end
            dfpm_pkg::ST_ACK: begin
                if (seg_left_q > dfpm_pkg::ONE_SEG) begin
                    state_d = dfpm_pkg::ST_COL; // [RQ13]
                end else begin
                    state_d = dfpm_pkg::ST_IDLE;
                end
            end
            default: state_d = dfpm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= dfpm_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Segment geometry of the running transfer
    // ------------------------------------------------------------
    logic [2:0] cur_olog, cur_plog, cur_wlog;
    logic [1:0] cur_off;
    logic [dfpm_pkg::SHIFT_W-1:0] cur_wbits;
    logic [dfpm_pkg::LANES-1:0] cur_lanes;
    logic [dfpm_pkg::DATA_W-1:0] rd_aligned, rd_piece;

    assign cur_olog = oper_log2(req_q.opw);
    assign cur_plog = port_log2(port_width_i[req_q.bank]);
    assign cur_wlog = (cur_olog < cur_plog) ? cur_olog : cur_plog;
    assign cur_off = req_q.addr[1:0] & 2'(((3'h1 << cur_plog) - 3'h1));
    assign cur_wbits = dfpm_pkg::BYTE_BITS << cur_wlog;
    assign cur_lanes = 4'(((5'h01 << (3'h1 << cur_wlog)) - 5'h01) << cur_off); // [RQ26]
    assign rd_aligned = dram_rdata_i << {cur_off, 3'h0};
    assign rd_piece = rd_aligned >> (dfpm_pkg::DATA_BITS - cur_wbits);

    // ------------------------------------------------------------
    // Request, burst and data registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            req_q <= '0;
            seg_left_q <= '0;
            wsh_q <= '0;
        end else if (accept) begin
            req_q <= req_i;
            seg_left_q <= req_nseg; // [RQ8]
            wsh_q <= req_i.wdata << req_wshift;
        end else if (state_q == dfpm_pkg::ST_ACK) begin
            seg_left_q <= seg_left_q - dfpm_pkg::ONE_SEG; // [RQ9]
            wsh_q <= wsh_q << cur_wbits;
            if (seg_left_q > dfpm_pkg::ONE_SEG) begin
                req_q.addr <= req_q.addr + (32'h0000_0001 << cur_plog); // [RQ13]
            end
        end
    end

    // Read data captured at the edge that ends the acknowledge cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsh_q <= '0;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= 1'b0;
            if (accept) begin
                rsh_q <= '0;
            end else if (state_q == dfpm_pkg::ST_ACK && !req_q.write) begin
                rsh_q <= (rsh_q << cur_wbits) | {96'h0, rd_piece}; // [RQ21]
                rdata_valid_q <= (seg_left_q == dfpm_pkg::ONE_SEG);
            end
        end
    end

    // Bus driven held over a running transfer after grant loss
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_driven_q <= 1'b0;
        end else begin
            bus_driven_q <= grant_ok || (state_q != dfpm_pkg::ST_IDLE); // [RQ24]
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [dfpm_pkg::ADDR_W-1:0] col_mask;
    logic active, start;

    assign col_mask = (dfpm_pkg::COL_MASK_512 << bank_page_size_i[req_q.bank])
                      | dfpm_pkg::COL_MASK_512;
    assign active = (state_q != dfpm_pkg::ST_IDLE);
    assign start = (state_q == dfpm_pkg::ST_ROW) || (state_q == dfpm_pkg::ST_HITR)
                   || (state_q == dfpm_pkg::ST_HITW);

    always_comb begin
        pins_o.ras_n = ~open_q; // [RQ5] [RQ13]
        pins_o.transfer_start_n = ~start; // [RQ9] [RQ12] [RQ19]
        pins_o.dram_write_n = active ? ~req_q.write : 1'b1;
        pins_o.operand_width = req_q.opw;
        if (state_q == dfpm_pkg::ST_ROW) begin
            pins_o.addr = req_q.addr & ~col_mask; // [RQ12]
        end else begin
            pins_o.addr = req_q.addr & col_mask; // [RQ5] [RQ19]
        end
        if (state_q == dfpm_pkg::ST_ACK) begin
            pins_o.cas_n = ~cur_lanes; // [RQ11] [RQ16] [RQ26]
        end else begin
            pins_o.cas_n = '1; // [RQ13]
        end
        pins_o.wdata = wsh_q[dfpm_pkg::OPER_W-1 -: dfpm_pkg::DATA_W] >> {cur_off, 3'h0};
        pins_o.data_oe = req_q.write && ((state_q == dfpm_pkg::ST_COL)
                         || (state_q == dfpm_pkg::ST_ACK)); // [RQ14] [RQ17]
    end

    // ------------------------------------------------------------
    // Core side outputs
    // ------------------------------------------------------------
    assign transfer_ack_o = (state_q == dfpm_pkg::ST_ACK); // [RQ9] [RQ21]
    assign rdata_o = rsh_q;
    assign rdata_valid_o = rdata_valid_q;
    assign bus_driven_n_o = ~bus_driven_q;

endmodule // dfpm_ctrl

// ==== src/dfpm_pkg.sv ====
// Shared constants, encodings and carrier types of the fast page mode DRAM controller
package dfpm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int OPER_W = 128;
    localparam int NUM_BANKS = 2;
    localparam int LANES = 4;
    localparam int ROW_LSB = 9;
    localparam int ROW_W = ADDR_W - ROW_LSB;
    localparam int SEG_W = 5;
    localparam int TIM_W = 4;
    localparam int SHIFT_W = 9;

    // ------------------------------------------------------------
    // Page size codes and column mask of the smallest page
    // ------------------------------------------------------------
    localparam logic [1:0] PS_512 = 2'h0;
    localparam logic [1:0] PS_1K = 2'h1;
    localparam logic [1:0] PS_2K = 2'h2;
    localparam logic [ADDR_W-1:0] COL_MASK_512 = 32'h0000_01FF;

    // ------------------------------------------------------------
    // Operand width and port width codes
    // ------------------------------------------------------------
    localparam logic [1:0] OPW_LONG = 2'h0;
    localparam logic [1:0] OPW_BYTE = 2'h1;
    localparam logic [1:0] OPW_WORD = 2'h2;
    localparam logic [1:0] OPW_LINE = 2'h3;
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;

    // Byte counts as log2
    localparam logic [2:0] LOG_1 = 3'h0;
    localparam logic [2:0] LOG_2 = 3'h1;
    localparam logic [2:0] LOG_4 = 3'h2;
    localparam logic [2:0] LOG_16 = 3'h4;

    // Bits per byte and full operand width as shift amounts
    localparam logic [SHIFT_W-1:0] BYTE_BITS = 9'h008;
    localparam logic [SHIFT_W-1:0] OPER_BITS = 9'h080;
    localparam logic [SHIFT_W-1:0] DATA_BITS = 9'h020;
    localparam logic [SEG_W-1:0] ONE_SEG = 5'h01;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ROW  = 3'b001,
        ST_COL  = 3'b010,
        ST_ACK  = 3'b011,
        ST_HITR = 3'b100,
        ST_HITW = 3'b101
    } dfpm_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic bank;
        logic [1:0] opw;
        logic [OPER_W-1:0] wdata;
    } dfpm_req_t;

    typedef struct packed {
        logic [TIM_W-1:0] row_prech;
        logic [TIM_W-1:0] col_prech;
    } dfpm_timing_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [NUM_BANKS-1:0] ras_n;
        logic [LANES-1:0] cas_n;
        logic dram_write_n;
        logic transfer_start_n;
        logic [1:0] operand_width;
        logic [DATA_W-1:0] wdata;
        logic data_oe;
    } dfpm_pins_t;

endpackage

// ==== src/dfpm_prech_cnt.sv ====
// Precharge down-counter: busy while programmed cycles remain
`timescale 1ns/10ps
module dfpm_prech_cnt #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic load_i,
    input wire logic [CNT_W-1:0] value_i,
    // Status
    output logic busy_o
);

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= value_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CNT_W'(1);
        end
    end

    assign busy_o = (cnt_q != '0);

endmodule // dfpm_prech_cnt

// ==== sim/dfpm_ctrl_chk.sv ====
// Port assertions of the fast page mode DRAM sequencer
`timescale 1ns/10ps
module dfpm_ctrl_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Observed ports
    input wire logic req_ready_o,
    input wire logic transfer_ack_o,
    input wire dfpm_pkg::dfpm_timing_t dram_timing_reg_i,
    input wire logic refresh_pend_i,
    input wire logic bus_driven_n_o,
    input wire dfpm_pkg::dfpm_pins_t pins_o
);
    // ----
    // Row strobe high time of bank 0, saturating
    // ----
    logic [4:0] hi_q;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hi_q <= 5'h1F;
        end else if (!pins_o.ras_n[0]) begin
            hi_q <= 5'h00;
        end else if (hi_q != 5'h1F) begin
            hi_q <= hi_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_start_single:
        assert property (!pins_o.transfer_start_n |=> pins_o.transfer_start_n)
        else $error("start strobe longer than one cycle");
    a_ack_cas_tie:
        assert property (transfer_ack_o == (pins_o.cas_n != 4'hF))
        else $error("acknowledge and column strobe disagree");
    a_cas_in_page:
        assert property (pins_o.cas_n != 4'hF |-> pins_o.ras_n != 2'h3)
        else $error("column strobe with no open row");
    a_new_page_seq:
        assert property (!pins_o.transfer_start_n && pins_o.ras_n != $past(pins_o.ras_n)
            |=> pins_o.transfer_start_n ##[1:16] transfer_ack_o)
        else $error("page opening sequence broken");
    a_read_hit:
        assert property (!pins_o.transfer_start_n && pins_o.dram_write_n
            && pins_o.ras_n == $past(pins_o.ras_n) && pins_o.ras_n != 2'h3 |=> transfer_ack_o)
        else $error("page hit read not acknowledged next cycle");
    a_write_hit:
        assert property (!pins_o.transfer_start_n && !pins_o.dram_write_n
            && pins_o.ras_n == $past(pins_o.ras_n) && pins_o.ras_n != 2'h3
            |=> !transfer_ack_o ##[1:16] transfer_ack_o)
        else $error("page hit write strobe timing wrong");
    a_data_first:
        assert property (pins_o.cas_n != 4'hF && !pins_o.dram_write_n
            |-> pins_o.data_oe && $past(pins_o.data_oe))
        else $error("write data not set up before column strobe");
    a_oe_write_only:
        assert property (pins_o.data_oe |-> !pins_o.dram_write_n && pins_o.transfer_start_n)
        else $error("data drivers on outside a write");
    a_row_prech:
        assert property ($fell(pins_o.ras_n[0]) |-> hi_q > 5'(dram_timing_reg_i.row_prech))
        else $error("row precharge too short");
    a_bd_held:
        assert property (transfer_ack_o |-> !bus_driven_n_o)
        else $error("bus driven released inside a transfer");
    a_refresh_block:
        assert property (refresh_pend_i |-> !req_ready_o)
        else $error("request taken with refresh pending");
endmodule // dfpm_ctrl_chk

bind dfpm_ctrl dfpm_ctrl_chk u_chk (.clk_i, .reset_i, .req_ready_o, .transfer_ack_o,
    .dram_timing_reg_i, .refresh_pend_i, .bus_driven_n_o, .pins_o);

// ==== sim/dfpm_dram_model.sv ====
// Behavioural page mode DRAM answering reads from the column address
`timescale 1ns/10ps
module dfpm_dram_model (
    // Clock
    input wire logic clk_i,
    // DRAM pins
    input wire dfpm_pkg::dfpm_pins_t pins_i,
    output logic [dfpm_pkg::DATA_W-1:0] rdata_o
);
    logic [7:0] col;
    logic [31:0] last_q = 32'h0000_0000;
    assign col = pins_i.addr[7:0];
    // Drives only under a read column strobe, else a flipping pattern
    assign rdata_o = (pins_i.cas_n != 4'hF && pins_i.dram_write_n) ?
        {col, ~col, col ^ 8'h3C, 8'h5A} : ~last_q;
    always_ff @(posedge clk_i) begin
        last_q <= rdata_o;
    end
endmodule // dfpm_dram_model

// ==== sim/test_dram_fast_page_mode_ctrl.sv ====
// Self-checking testbench of the fast page mode DRAM sequencer
`timescale 1ns/10ps
module test_dram_fast_page_mode_ctrl;
    // ----
    // Stimulus and observation
    // ----
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic refresh_pend_i = 1'b0;
    logic bus_lock_i = 1'b0;
    logic bus_grant_in_n_i = 1'b0;
    logic req_ready_o, transfer_ack_o, rdata_valid_o, bus_driven_n_o, rdy, bd, rv;
    logic [1:0][1:0] bank_page_size_i = {2'h2, 2'h0};
    logic [1:0][1:0] port_width_i = {2'h1, 2'h0};
    logic [127:0] rdata_o, wcap, rd;
    logic [127:0] wd = '0;
    logic [31:0] dram_rdata_i;
    logic [3:0] cas0;
    dfpm_pkg::dfpm_req_t req_i = '0;
    dfpm_pkg::dfpm_timing_t dram_timing_reg_i = '0;
    dfpm_pkg::dfpm_pins_t pins_o, snap;
    int n_mismatch = 0;
    int num_checks = 0;

    initial forever #4 clk_i = ~clk_i;

    dfpm_ctrl dut (.clk_i, .reset_i, .req_valid_i, .req_i, .req_ready_o, .transfer_ack_o,
        .rdata_o, .rdata_valid_o, .bank_page_size_i, .port_width_i, .dram_timing_reg_i,
        .refresh_pend_i, .bus_lock_i, .bus_grant_in_n_i, .bus_driven_n_o, .pins_o,
        .dram_rdata_i);
    dfpm_dram_model u_dram (.clk_i, .pins_i(pins_o), .rdata_o(dram_rdata_i));

    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Samples settled outputs mid-cycle
    task automatic look;
        @(negedge clk_i);
        snap = pins_o;
        rdy = req_ready_o;
        bd = bus_driven_n_o;
        rv = rdata_valid_o;
        @(posedge clk_i);
    endtask

    // One transfer; cycles counted from first valid
    task automatic xfer(input logic [31:0] a, input logic w, input logic b,
        input logic [1:0] o, input int ns, input int lat);
        int t, n, ts, f, l;
        logic tk;
        t = 0;
        n = 0;
        ts = 0;
        f = -1;
        l = -1;
        req_i <= '{addr: a, write: w, bank: b, opw: o, wdata: wd};
        req_valid_i <= 1'b1;
        while (n < ns && t < 100) begin
            @(negedge clk_i);
            tk = req_valid_i && req_ready_o === 1'b1;
            ts += int'(pins_o.transfer_start_n === 1'b0);
            if (transfer_ack_o === 1'b1) begin
                if (n == 0) begin
                    f = t;
                    cas0 = pins_o.cas_n;
                end
                l = t;
                wcap = {wcap[95:0], pins_o.wdata};
                n++;
            end
            @(posedge clk_i);
            if (tk) begin
                req_valid_i <= 1'b0;
            end
            t++;
        end
        look();
        rd = rdata_o;
        chk("first ack", lat, f);
        chk("last ack", lat + (2 + dram_timing_reg_i.col_prech) * (ns - 1), l);
        chk("read valid", !w, rv);
        chk("size code", o, snap.operand_width);
        chk("acks", ns, n);
        chk("starts", 1, ts);
    endtask

    task automatic t_open_hit;
        dram_timing_reg_i.col_prech <= 4'h2;
        xfer(32'h0000_1004, 1'b0, 1'b0, 2'h0, 1, 3);
        chk("read data", 32'h04FB_385A, rd[31:0]);
        chk("lanes", 4'h0, cas0);
        dram_timing_reg_i <= '0;
        xfer(32'h0000_1008, 1'b0, 1'b0, 2'h0, 1, 3);
        chk("read data", 32'h08F7_345A, rd[31:0]);
    endtask

    task automatic t_write_burst;
        wd = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
        xfer(32'h0000_1010, 1'b1, 1'b0, 2'h3, 4, 3);
        chk("write data", wd, wcap);
    endtask

    task automatic t_page_size;
        logic [31:0] a;
        for (int p = 0; p < 3; p++) begin
            bank_page_size_i[0] <= 2'(p);
            a = 32'h0001_0000 << p;
            xfer(a, 1'b0, 1'b0, 2'h0, 1, 4);
            xfer(a ^ (32'h0000_0001 << (8 + p)), 1'b0, 1'b0, 2'h0, 1, 2);
            xfer(a ^ (32'h0000_0001 << (9 + p)), 1'b0, 1'b0, 2'h0, 1, 4);
        end
    endtask

    task automatic t_other_bank;
        dram_timing_reg_i.col_prech <= 4'h1;
        xfer(32'h8000_0002, 1'b0, 1'b1, 2'h2, 2, 3);
        chk("read data", 16'h0203, rd[15:0]);
        chk("lanes", 4'hE, cas0);
        look();
        chk("row strobes", 2'h1, snap.ras_n);
        dram_timing_reg_i.row_prech <= 4'h2;
        xfer(32'h8000_1000, 1'b0, 1'b1, 2'h2, 2, 6);
        dram_timing_reg_i <= '0;
    endtask

    task automatic t_refresh;
        xfer(32'h0000_1004, 1'b0, 1'b0, 2'h0, 1, 3);
        refresh_pend_i <= 1'b1;
        repeat (3) look();
        chk("row strobes", 2'h3, snap.ras_n);
        chk("ready", 1'b0, rdy);
        refresh_pend_i <= 1'b0;
        repeat (4) look();
        xfer(32'h0000_1004, 1'b0, 1'b0, 2'h0, 1, 3);
    endtask

    task automatic t_grant;
        bus_grant_in_n_i <= 1'b1;
        xfer(32'h0000_1000, 1'b0, 1'b0, 2'h3, 4, 2);
        chk("read data", 128'h00FF_3C5A_04FB_385A_08F7_345A_0CF3_305A, rd);
        repeat (6) look();
        chk("bus driven", 1'b1, bd);
        chk("row strobes", 2'h3, snap.ras_n);
        bus_grant_in_n_i <= 1'b0;
        bus_lock_i <= 1'b1;
        repeat (6) look();
        xfer(32'h0000_1000, 1'b0, 1'b0, 2'h0, 1, 3);
        bus_grant_in_n_i <= 1'b1;
        repeat (6) look();
        chk("row strobes", 2'h2, snap.ras_n);
        chk("bus driven", 1'b0, bd);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        t_open_hit();
        t_write_burst();
        t_page_size();
        t_other_bank();
        t_refresh();
        t_grant();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
endmodule // test_dram_fast_page_mode_ctrl
